//--- hw/awr_top.sv
// adc result, staging, window limit and clock trim registers behind an apb slave
// Overview of operation
// - debug_continue low halts converter, drops events while cpu halted
// - one shared staging byte for 16-bit access
// - staging byte directly readable, writable, resets zero
// - low byte at base, high byte base+1
// - samples clamp to 0x3FF and 0x000
// - accumulated result never exceeds 0xFFC0
// - result register read-only unsigned magnitude
// - window compares final accumulated value only
// - low limit read/write, resets zero
// - high limit read/write, resets zero
// - duty select resets one; 25% else 50%
// - mode field: none, below, above, inside, outside
// - match flag: set at end, w1c, low result read clears
`default_nettype none
module awr_top (
	input  wire logic                   i_sys_clk,       // 25 MHz system clock
	input  wire logic                   i_arst_n,        // async reset, active low
	input  wire logic                   i_clk_en,        // freezes all state when low
	input  wire logic                   i_psel,          // apb select
	input  wire logic                   i_penable,       // apb access phase
	input  wire logic                   i_pwrite,        // apb direction, 1 write
	input  wire logic [9:0]             i_paddr,         // apb byte address
	input  wire logic [31:0]            i_pwdata,        // apb write data
	input  wire logic [3:0]             i_pstrb,         // apb byte strobes
	input  wire logic                   i_cpu_halted,    // cpu stopped in break debug
	input  wire logic                   i_start_evt,     // incoming start event pulse
	input  wire logic                   i_sample_valid,  // converter sample pulse
	input  wire logic [11:0]            i_sample_raw,    // signed raw sample
	input  wire logic                   i_sample_last,   // last sample of accumulation
	output logic [31:0]                 o_prdata,        // apb read data
	output logic                        o_pready,        // apb ready
	output logic                        o_pslverr,       // apb error, unmapped address
	output logic                        o_irq,           // level interrupt
	output logic                        o_start_evt,     // start event passed to core
	output logic                        o_conv_run,      // converter may run
	output logic                        o_adc_clk        // converter clock
);
	import awr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// register state
	logic        dbg_cont;                  // debug_continue
	logic [7:0]  staging;                   // staging_byte
	logic [15:0] result;                    // sample_outcome
	logic [15:0] win_lo;                    // window_low_limit
	logic [15:0] win_hi;                    // window_high_limit
	logic        duty_sel;                  // clock_duty_select
	logic [2:0]  cmp_mode;                  // window_compare_mode
	logic [1:0]  flags;                     // sticky status
	logic [1:0]  mask;                      // interrupt mask
	awr_acc_e    acc_state;                 // accumulation sequencer
	logic [15:0] acc_sum;                   // running sum
	logic [6:0]  acc_cnt;                   // samples taken so far

	////////////////////////////////////////////////////////////////////////////
	// address decode
	function automatic logic at_idx(input logic [9:0] addr, input logic [7:0] idx);
		at_idx = (addr[1:0] == 2'b00) && (addr[9:2] == idx);
	endfunction

	wire hit_dbg   = at_idx(i_paddr, IDX_DBG);
	wire hit_temp  = at_idx(i_paddr, IDX_TEMP);
	wire hit_res_l = at_idx(i_paddr, IDX_RES_L);
	wire hit_res_h = at_idx(i_paddr, IDX_RES_H);
	wire hit_wlo_l = at_idx(i_paddr, IDX_WLO_L);
	wire hit_wlo_h = at_idx(i_paddr, IDX_WLO_H);
	wire hit_whi_l = at_idx(i_paddr, IDX_WHI_L);
	wire hit_whi_h = at_idx(i_paddr, IDX_WHI_H);
	wire hit_cal   = at_idx(i_paddr, IDX_CAL);
	wire hit_mode  = at_idx(i_paddr, IDX_MODE);
	wire hit_flags = at_idx(i_paddr, IDX_FLAGS);
	wire hit_mask  = at_idx(i_paddr, IDX_MASK);
	wire mapped    = hit_dbg | hit_temp | hit_res_l | hit_res_h | hit_wlo_l | hit_wlo_h
	               | hit_whi_l | hit_whi_h | hit_cal | hit_mode | hit_flags | hit_mask;

	// phase strobes; side effects happen only on the completing edge
	wire setup    = i_psel && !i_penable;
	wire xfer_end = i_psel && i_penable && o_pready;
	wire wr_en    = xfer_end && i_pwrite && mapped && i_pstrb[0];
	wire rd_en    = xfer_end && !i_pwrite && mapped;
	wire [7:0] wbyte = i_pwdata[7:0];

	// read byte; high halves come out of staging, filled by the low read
	wire [7:0] rd_byte =
		hit_dbg   ? {7'h00, dbg_cont} :
		hit_temp  ? staging :
		hit_res_l ? result[7:0] :
		hit_wlo_l ? win_lo[7:0] :
		hit_whi_l ? win_hi[7:0] :
		(hit_res_h | hit_wlo_h | hit_whi_h) ? staging :
		hit_cal   ? {7'h00, duty_sel} :
		hit_mode  ? {5'h00, cmp_mode} :
		hit_flags ? {6'h00, flags} :
		hit_mask  ? {6'h00, mask} : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// apb answer: ready in the first access cycle, data latched at setup
	// no wait states: read data is taken at the setup edge, so it shows the
	// register as it was before any side effect of this same transfer
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0000_0000;
		end else if (i_clk_en) begin
			o_pready  <= setup;
			o_pslverr <= setup && !mapped;
			o_prdata  <= (setup && !i_pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// plain control registers
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dbg_cont <= DBG_RST;
			duty_sel <= DUTY_RST;
			cmp_mode <= MODE_RST;
			mask     <= FLAGS_RST;
		end else if (i_clk_en) begin
			if (wr_en && hit_dbg)
				dbg_cont <= wbyte[DBG_CONT_BIT];
			if (wr_en && hit_cal)
				duty_sel <= wbyte[DUTY_BIT];
			if (wr_en && hit_mode)
				cmp_mode <= wbyte[2:0];
			if (wr_en && hit_mask)
				mask <= wbyte[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// staging byte and the 16-bit limit pairs
	wire lo_write = wr_en && (hit_wlo_l || hit_whi_l);     // low byte parks in staging
	wire [7:0] next_staging =
		(wr_en && hit_temp) ? wbyte :
		lo_write            ? wbyte :
		(rd_en && hit_res_l) ? result[15:8] :
		(rd_en && hit_wlo_l) ? win_lo[15:8] :
		(rd_en && hit_whi_l) ? win_hi[15:8] : staging;

	// one staging byte serves every pair, so interleaved pair accesses collide
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			staging <= TEMP_RST;
			win_lo  <= WORD_RST;
			win_hi  <= WORD_RST;
		end else if (i_clk_en) begin
			staging <= next_staging;
			if (wr_en && hit_wlo_h)
				win_lo <= {wbyte, staging};
			if (wr_en && hit_whi_h)
				win_hi <= {wbyte, staging};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// debug halt: converter and its event input stop unless told to continue
	wire run_ok = !i_cpu_halted || dbg_cont;

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_conv_run  <= 1'b0;
			o_start_evt <= 1'b0;
		end else if (i_clk_en) begin
			o_conv_run  <= run_ok;
			o_start_evt <= i_start_evt && run_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sample clamp and accumulation
	wire [9:0] clamped =
		i_sample_raw[11] ? 10'h000 :
		(i_sample_raw[10:0] > {1'b0, SAMPLE_MAX}) ? SAMPLE_MAX :
		i_sample_raw[9:0];

	// a sample is dropped while halted or in the one end cycle
	wire        take     = i_sample_valid && run_ok && (acc_state != AWR_ACC_END);
	wire [16:0] sum_wide = ((acc_state == AWR_ACC_IDLE) ? 17'h0_0000 : {1'b0, acc_sum})
	                     + {7'h00, clamped};
	wire [15:0] sum_cap  = (sum_wide > {1'b0, ACC_LIMIT}) ? ACC_LIMIT : sum_wide[15:0];
	wire [6:0]  next_cnt = ((acc_state == AWR_ACC_IDLE) ? 7'h00 : acc_cnt) + 7'h01;
	wire        fin_take = take && (i_sample_last || next_cnt == ACC_MAX_N);

	// sequencer: idle -> run while summing -> end for one cycle
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			acc_state <= AWR_ACC_IDLE;
			acc_sum   <= WORD_RST;
			acc_cnt   <= 7'h00;
			result    <= WORD_RST;
		end else if (i_clk_en) begin
			unique case (acc_state)
				AWR_ACC_IDLE, AWR_ACC_RUN: begin
					if (take) begin
						acc_sum   <= sum_cap;
						acc_cnt   <= next_cnt;
						acc_state <= fin_take ? AWR_ACC_END : AWR_ACC_RUN;
					end
					if (fin_take)
						result <= sum_cap;
				end
				AWR_ACC_END: begin
					acc_state <= AWR_ACC_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// window comparison on the stored final result
	logic win_hit;                                          // result matches mode

	awr_win_cmp u_win_cmp (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_value   (result),
		.i_lo      (win_lo),
		.i_hi      (win_hi),
		.i_mode    (cmp_mode),
		.o_match   (win_hit)
	);

	////////////////////////////////////////////////////////////////////////////
	// sticky flags: a set in the same cycle as a clear wins
	wire       at_end   = acc_state == AWR_ACC_END;
	wire [1:0] flag_set = {at_end && win_hit, at_end};
	wire [1:0] flag_clr = ((wr_en && hit_flags) ? wbyte[1:0] : 2'b00)
	                    | ((rd_en && hit_res_l) ? 2'b11 : 2'b00);
	wire [1:0] next_flags = (flags & ~flag_clr) | flag_set;
	// mask taken at its new value, so a mask write reaches the pin at once
	wire [1:0] next_mask  = (wr_en && hit_mask) ? wbyte[1:0] : mask;

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flags <= FLAGS_RST;
			o_irq <= 1'b0;
		end else if (i_clk_en) begin
			flags <= next_flags;
			o_irq <= |(next_flags & next_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// converter clock
	awr_duty_clk u_duty_clk (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_clk_en  (i_clk_en),
		.i_run     (run_ok),
		.i_quarter (duty_sel),
		.o_clk     (o_adc_clk)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_low_read;
		rd_en && hit_res_l && i_clk_en;
	endsequence

	sequence s_end_match;
		at_end && win_hit && i_clk_en;
	endsequence

	sequence s_quarter_high;
		o_adc_clk && duty_sel && i_clk_en;
	endsequence

	chk_halt_drops_evt: assert property (
		(i_clk_en && i_cpu_halted && !dbg_cont) |=> (!o_start_evt && !o_conv_run))
		else $error("event passed while halted in debug");

	chk_staging_copy: assert property (
		s_low_read |=> staging == $past(result[15:8]))
		else $error("low result read did not copy high byte");

	chk_staging_write: assert property (
		(wr_en && hit_temp && i_clk_en) |=> staging == $past(wbyte))
		else $error("staging byte write lost");

	chk_low_pair_commit: assert property (
		(wr_en && hit_wlo_h && i_clk_en) |=> win_lo == {$past(wbyte), $past(staging)})
		else $error("low limit pair not committed");

	chk_high_pair_commit: assert property (
		(wr_en && hit_whi_h && i_clk_en) |=> win_hi == {$past(wbyte), $past(staging)})
		else $error("high limit pair not committed");

	chk_clamp_range: assert property (
		(i_sample_raw[11] |-> clamped == 10'h000) and
		(!i_sample_raw[11] && i_sample_raw[10] |-> clamped == SAMPLE_MAX))
		else $error("sample clamp wrong");

	chk_result_bound: assert property (
		result <= ACC_LIMIT)
		else $error("result above accumulation limit");

	chk_result_readonly: assert property (
		(wr_en && (hit_res_l || hit_res_h) && !fin_take) |=> result == $past(result))
		else $error("result changed by a write");

	chk_match_sets_flag: assert property (
		s_end_match |=> flags[FLAG_WMATCH] ##1 1'b1)
		else $error("window match did not set flag");

	chk_read_clears_flag: assert property (
		(s_low_read and !at_end) |=> flags == 2'b00)
		else $error("result read did not clear flags");

	chk_zero_write_keeps: assert property (
		(wr_en && hit_flags && wbyte[1:0] == 2'b00 && !at_end && i_clk_en && !rd_en)
			|=> flags == $past(flags))
		else $error("writing zero changed a flag");

	// a set in the end cycle must survive a clear that lands on the same edge
	chk_set_beats_clear: assert property (
		(at_end && i_clk_en) |=> flags[FLAG_RESRDY])
		else $error("result ready flag lost to a clear");

	// the interrupt pin is a registered copy of the masked status
	chk_irq_follows: assert property (
		o_irq == |(flags & mask))
		else $error("interrupt level disagrees with masked status");

	// a halted converter must see its clock parked low
	chk_halt_clock_low: assert property (
		(i_clk_en && !run_ok) |=> !o_adc_clk)
		else $error("converter clock ran while halted");

	// quarter duty: a high phase lasts exactly one system cycle
	chk_quarter_duty: assert property (
		s_quarter_high |=> !o_adc_clk)
		else $error("quarter duty clock stayed high");

endmodule
`default_nettype wire

//--- inc/awr_pkg.sv
// package: offsets, fields, reset values and timing for the adc result/window register bank
`default_nettype none
package awr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register indices; byte address on the bus is index times four
	localparam logic [7:0] IDX_DBG    = 8'h0C;      // debug_halt_control
	localparam logic [7:0] IDX_TEMP   = 8'h0D;      // staging_byte
	localparam logic [7:0] IDX_RES_L  = 8'h10;      // sample_outcome low byte
	localparam logic [7:0] IDX_RES_H  = 8'h11;      // sample_outcome high byte
	localparam logic [7:0] IDX_WLO_L  = 8'h12;      // window_low_limit low byte
	localparam logic [7:0] IDX_WLO_H  = 8'h13;      // window_low_limit high byte
	localparam logic [7:0] IDX_WHI_L  = 8'h14;      // window_high_limit low byte
	localparam logic [7:0] IDX_WHI_H  = 8'h15;      // window_high_limit high byte
	localparam logic [7:0] IDX_CAL    = 8'h16;      // clock_trim_setting
	localparam logic [7:0] IDX_MODE   = 8'h18;      // window_compare_mode
	localparam logic [7:0] IDX_FLAGS  = 8'h19;      // interrupt status, write one to clear
	localparam logic [7:0] IDX_MASK   = 8'h1A;      // interrupt mask

	////////////////////////////////////////////////////////////////////////////
	// field positions and reset values
	localparam int         DBG_CONT_BIT  = 0;        // debug_continue
	localparam int         DUTY_BIT      = 0;        // clock_duty_select
	localparam int         FLAG_RESRDY   = 0;        // result ready flag
	localparam int         FLAG_WMATCH   = 1;        // window_match_flag
	localparam logic       DBG_RST       = 1'b0;
	localparam logic [7:0] TEMP_RST      = 8'h00;
	localparam logic [15:0] WORD_RST     = 16'h0000;
	localparam logic       DUTY_RST      = 1'b1;     // quarter duty after reset
	localparam logic [2:0] MODE_RST      = 3'h0;
	localparam logic [1:0] FLAGS_RST     = 2'h0;

	////////////////////////////////////////////////////////////////////////////
	// sample and accumulation limits
	localparam logic [9:0]  SAMPLE_MAX   = 10'h3FF;  // full scale of one sample
	localparam logic [15:0] ACC_LIMIT    = 16'hFFC0; // 64 full-scale samples
	localparam logic [6:0]  ACC_MAX_N    = 7'h40;    // at most 64 accumulations

	////////////////////////////////////////////////////////////////////////////
	// converter clock timing
	localparam int         CLK_NS        = 40;       // system clock period
	localparam int         ADC_CLK_NS    = 160;      // converter clock period
	localparam int         ADC_DIV       = ADC_CLK_NS / CLK_NS;
	localparam logic [1:0] DIV_LAST      = 2'(ADC_DIV - 1);
	localparam logic [2:0] HIGH_QUARTER  = 3'(ADC_DIV / 4);
	localparam logic [2:0] HIGH_HALF     = 3'(ADC_DIV / 2);

	////////////////////////////////////////////////////////////////////////////
	// window comparison modes
	typedef enum logic [2:0] {
		AWR_WIN_NONE    = 3'h0,
		AWR_WIN_BELOW   = 3'h1,
		AWR_WIN_ABOVE   = 3'h2,
		AWR_WIN_INSIDE  = 3'h3,
		AWR_WIN_OUTSIDE = 3'h4
	} awr_win_e;

	// accumulation sequencer, gray along idle -> run -> end
	typedef enum logic [1:0] {
		AWR_ACC_IDLE = 2'b00,
		AWR_ACC_RUN  = 2'b01,
		AWR_ACC_END  = 2'b11
	} awr_acc_e;

endpackage
`default_nettype wire

//--- hw/awr_win_cmp.sv
// window comparator: tests the final result against the low and high limits
`default_nettype none
module awr_win_cmp (
	input  wire logic                   i_sys_clk,  // clock, only for checks
	input  wire logic                   i_arst_n,   // reset, only for checks
	input  wire logic [15:0]            i_value,    // accumulated result
	input  wire logic [15:0]            i_lo,       // low limit
	input  wire logic [15:0]            i_hi,       // high limit
	input  wire logic [2:0]             i_mode,     // comparison mode code
	output logic                        o_match     // result satisfies mode
);
	import awr_pkg::*;

	// plain unsigned compares; the data never go negative
	wire below = i_value < i_lo;
	wire above = i_value > i_hi;

	// mode select; reserved codes never match
	always_comb begin
		unique case (i_mode)
			AWR_WIN_NONE:    o_match = 1'b0;
			AWR_WIN_BELOW:   o_match = below;
			AWR_WIN_ABOVE:   o_match = above;
			AWR_WIN_INSIDE:  o_match = (i_value > i_lo) && (i_value < i_hi);
			AWR_WIN_OUTSIDE: o_match = below || above;
			default:         o_match = 1'b0;               // reserved code
		endcase
	end

	chk_reserved_no_match: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		(i_mode > 3'h4 || i_mode == 3'h0) |-> !o_match)
		else $error("window match raised for none or reserved mode");

endmodule
`default_nettype wire

//--- hw/awr_duty_clk.sv
// converter clock divider with quarter or half high time
`default_nettype none
module awr_duty_clk (
	input  wire logic                   i_sys_clk,  // system clock
	input  wire logic                   i_arst_n,   // async reset, active low
	input  wire logic                   i_clk_en,   // freezes state when low
	input  wire logic                   i_run,      // converter allowed to run
	input  wire logic                   i_quarter,  // 1: 25% high, 0: 50% high
	output logic                        o_clk       // converter clock
);
	import awr_pkg::*;

	logic [1:0] phase;                              // position inside period
	wire  [1:0] next_phase = (phase == DIV_LAST) ? 2'b00 : phase + 2'b01;
	wire  [2:0] high_len   = i_quarter ? HIGH_QUARTER : HIGH_HALF;
	wire        next_clk   = i_run && ({1'b0, next_phase} < high_len);

	// divider; a halted converter sees its clock parked low
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			phase <= 2'b00;
			o_clk <= 1'b0;
		end else if (i_clk_en) begin
			phase <= i_run ? next_phase : phase;
			o_clk <= next_clk;
		end
	end

endmodule
`default_nettype wire

//--- sim/test_awr_top.sv
// self-checking testbench for the adc result, staging, window and clock trim registers
`default_nettype none
module test_awr_top;
	timeunit 1ns;
	timeprecision 1ps;
	import awr_pkg::*;
	`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
		$display("Error %0t: got %h expected %h", $time, a, b); end end

	////////////////////////////////////////////////////////////////////////////
	logic        clk, rst_n, psel, pen, pwr, halted, sevt, sv, slast; // bench-driven
	logic [9:0]  paddr;                                             // byte address
	logic [31:0] pwdata, prdata;                                    // apb data
	logic [11:0] raw;                                               // signed sample
	logic        pready, pslverr, irq, oevt, run, aclk;             // dut outputs
	logic [7:0]  rd;                                                // last read byte
	logic        er;                                                // last error bit
	logic [15:0] v, v0;                                             // 16-bit reads
	int          n_fail, comparisons, c;                            // counters

	// clock enable and strobes tied: every write is a full byte write
	awr_top dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_clk_en(1'b1), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(4'hf), .i_cpu_halted(halted), .i_start_evt(sevt), .i_sample_valid(sv),
		.i_sample_raw(raw), .i_sample_last(slast), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_irq(irq), .o_start_evt(oevt), .o_conv_run(run),
		.o_adc_clk(aclk));

	////////////////////////////////////////////////////////////////////////////
	// one apb transfer; waits for pready without assuming a latency, the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	// low byte first so the high byte comes from staging
	task automatic rd16(input logic [7:0] idx, output logic [15:0] r);
		apb(1'b0, idx, 8'h00);
		r[7:0] = rd;
		apb(1'b0, idx + 8'h01, 8'h00);
		r[15:8] = rd;
	endtask

	// one sample pulse, then a spare cycle so the next pulse never lands in the end state
	task automatic smp(input logic [11:0] r, input logic l);
		@(posedge clk);
		sv    <= 1'b1;
		raw   <= r;
		slast <= l;
		@(posedge clk);
		sv    <= 1'b0;
		slast <= 1'b0;
		raw   <= ~r;
		@(posedge clk);
	endtask

	// count high cycles of a signal over eight clocks
	task automatic cnt8(input int sel);
		c = 0;
		repeat (8) begin
			@(posedge clk);
			c += (sel == 0) ? int'(aclk === 1'b1) : int'(oevt === 1'b1);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		apb(1'b0, IDX_DBG, 8'h00);
		`CHK(rd, 8'h00)
		apb(1'b0, IDX_TEMP, 8'h00);
		`CHK(rd, 8'h00)
		rd16(IDX_RES_L, v);
		`CHK(v, 16'h0000)
		rd16(IDX_WLO_L, v);
		`CHK(v, 16'h0000)
		rd16(IDX_WHI_L, v);
		`CHK(v, 16'h0000)
		apb(1'b0, IDX_CAL, 8'h00);
		`CHK(rd, 8'h01)
		apb(1'b0, 8'h0E, 8'h00);
		`CHK({er, rd}, 9'h100)
	endtask

	task automatic t_pair();
		wr(IDX_TEMP, 8'ha5);
		apb(1'b0, IDX_TEMP, 8'h00);
		`CHK(rd, 8'ha5)
		wr(IDX_WLO_L, 8'h34);
		wr(IDX_WLO_H, 8'h12);
		wr(IDX_WHI_L, 8'hcd);
		wr(IDX_WHI_H, 8'hab);
		wr(IDX_WLO_L, 8'h77); // staged only, never committed
		rd16(IDX_WLO_L, v);
		`CHK(v, 16'h1234)
		apb(1'b0, IDX_TEMP, 8'h00);
		`CHK(rd, 8'h12)
		rd16(IDX_WHI_L, v);
		`CHK(v, 16'habcd)
		wr(IDX_RES_L, 8'hff);
		wr(IDX_RES_H, 8'hff);
		rd16(IDX_RES_L, v);
		`CHK(v, 16'h0000)
	endtask

	task automatic t_sample();
		smp(12'hfff, 1'b1);
		rd16(IDX_RES_L, v);
		`CHK(v, 16'h0000)
		smp(12'h7ff, 1'b1);
		rd16(IDX_RES_L, v);
		`CHK(v, 16'h03ff)
		repeat (64) smp(12'h500, 1'b0);
		rd16(IDX_RES_L, v);
		`CHK(v, 16'hffc0)
		smp(12'h001, 1'b1);
		rd16(IDX_RES_L, v);
		`CHK(v, 16'h0001)
	endtask

	// limits 0x0100..0x0300; each sum is made of two equal samples
	task automatic t_window();
		logic [15:0] s;
		logic        e;
		wr(IDX_WLO_L, 8'h00);
		wr(IDX_WLO_H, 8'h01);
		wr(IDX_WHI_L, 8'h00);
		wr(IDX_WHI_H, 8'h03);
		for (int m = 0; m < 8; m++) begin
			for (int i = 0; i < 3; i++) begin
				s = (i == 0) ? 16'h0028 : (i == 1) ? 16'h0100 : 16'h01ff;
				e = (m == 1) ? (2 * s < 16'h0100) : (m == 2) ? (2 * s > 16'h0300) :
					(m == 3) ? (2 * s > 16'h0100 && 2 * s < 16'h0300) :
					(m == 4) ? (2 * s < 16'h0100 || 2 * s > 16'h0300) : 1'b0;
				wr(IDX_MODE, 8'(m));
				wr(IDX_FLAGS, 8'h03);
				smp(s[11:0], 1'b0);
				smp(s[11:0], 1'b1);
				apb(1'b0, IDX_FLAGS, 8'h00);
				`CHK(rd, {6'h00, e, 1'b1})
			end
		end
	endtask

	task automatic t_flags();
		wr(IDX_MODE, 8'h03);
		smp(12'h100, 1'b0);
		smp(12'h100, 1'b1); // sum 0x200 lies inside in mode 3
		wr(IDX_FLAGS, 8'h00);
		apb(1'b0, IDX_FLAGS, 8'h00);
		`CHK(rd, 8'h03)
		wr(IDX_MASK, 8'h02);
		@(negedge clk);
		`CHK(irq, 1'b1)
		wr(IDX_MASK, 8'h00);
		@(negedge clk);
		`CHK(irq, 1'b0)
		wr(IDX_MASK, 8'h02);
		rd16(IDX_RES_L, v);
		@(negedge clk);
		`CHK(irq, 1'b0)
		smp(12'h100, 1'b1); // 0x100 equals low limit, so no match
		wr(IDX_FLAGS, 8'h01);
		apb(1'b0, IDX_FLAGS, 8'h00);
		`CHK(rd, 8'h00)
	endtask

	task automatic t_debug();
		wr(IDX_DBG, 8'h00);
		rd16(IDX_RES_L, v0);
		@(posedge clk);
		halted <= 1'b1;
		sevt   <= 1'b1;
		@(posedge clk);
		sevt <= 1'b0;
		cnt8(1);
		`CHK(c, 0)
		`CHK(run, 1'b0)
		cnt8(0);
		`CHK(c, 0)
		smp(12'h055, 1'b1);
		rd16(IDX_RES_L, v);
		`CHK(v, v0)
		wr(IDX_DBG, 8'h01);
		@(posedge clk);
		sevt <= 1'b1;
		@(posedge clk);
		sevt <= 1'b0;
		cnt8(1);
		`CHK(c, 1)
		smp(12'h055, 1'b1);
		rd16(IDX_RES_L, v);
		`CHK(v, 16'h0055)
	endtask

	task automatic t_duty();
		@(posedge clk);
		halted <= 1'b0;
		repeat (2) @(posedge clk);
		cnt8(0);
		`CHK(c, 2)
		wr(IDX_CAL, 8'h00);
		@(posedge clk); // let the last quarter-duty phase pass
		cnt8(0);
		`CHK(c, 4)
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// watchdog, well beyond the roughly eight hundred cycles the tests take
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		results();
	end

	initial begin
		{rst_n, psel, pen, pwr, halted, sevt, sv, slast} = 8'h00;
		paddr  = 10'h000;
		pwdata = 32'h0000_0000;
		raw    = 12'h000;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_pair();
		t_sample();
		t_window();
		t_flags();
		t_debug();
		t_duty();
		results();
	end
endmodule
`default_nettype wire
